//--- rtl/cmc_clock_mode_control.sv
/*
 * Core clock mode control: host register file behind the parallel host pins,
 * multiplier and clock relation selects, sample slot phase counter and
 * downsample strobe, and a configuration consistency status.
 * Assumes host pins are asynchronous to clk_sys and a host strobe lasts at
 * least three clk_sys cycles; the bidirectional data wire is resolved outside.
 */
`timescale 1ns/10ps
module cmc_clock_mode_control
   import cmc_pkg::*;
(
   input  wire logic              clk_sys,
   input  wire logic              arst_n,
   input  wire logic [ADDR_W-1:0] host_addr,
   input  wire logic [DATA_W-1:0] host_data_in,
   output logic      [DATA_W-1:0] host_data_out,
   output logic                   host_data_oe,
   input  wire logic              host_cs_n,
   input  wire logic              host_rd_n,
   input  wire logic              host_wr_n,
   input  wire logic              sync_in,
   output logic      [1:0]        mult_sel,
   output logic                   mult_bypass,
   output logic                   feedback_src,
   output logic      [1:0]        in_clk_relation,
   output logic      [1:0]        out_clk_relation,
   output logic                   two_channel,
   output logic                   in_muxed,
   output logic      [1:0]        out_format,
   output logic      [1:0]        upsample_mode,
   output logic      [2:0]        downsample_factor,
   output logic      [1:0]        slot_phase,
   output logic                   slot_strobe,
   output logic                   downsample_strobe,
   output logic      [4:0]        config_error
);

   typedef struct packed {
      logic [2:0][ADDR_W-1:0] addr_sync;
      logic [2:0][DATA_W-1:0] data_sync;
      logic [2:0]             cs_sync;
      logic [2:0]             rd_sync;
      logic [2:0]             wr_sync;
      logic [2:0]             align_sync;
      logic [15:0]            mult_reg;
      logic [15:0]            rel_reg;
      logic [15:0]            fmt_reg;
      logic [15:0]            ds_reg;
      logic [15:0]            up_reg;
      logic [DATA_W-1:0]      rdata;
      logic                   oe;
      logic [1:0]             phase;
      logic                   slot;
      logic [1:0]             ds_count;
      logic                   ds_stb;
      logic [4:0]             err;
      logic [1:0]             mult;
      logic                   bypass;
   } cmc_state_s;

   cmc_state_s st_q;
   cmc_state_s st_d;
   logic       wr_stb;
   logic       align_evt;

   // Decimation code to a count of slots minus one; illegal codes map to zero.
   function automatic logic [1:0] ds_last(input logic [2:0] code);
      logic [1:0] r;
      r = 2'h0;
      if (code == DS_BY_2) begin
         r = 2'h1;
      end else if (code == DS_BY_4) begin
         r = 2'h3;
      end
      return r;
   endfunction

   always_comb begin
      st_d = st_q;
      // Pins pass two flops; writes take address, data and chip select from the third stage.
      st_d.addr_sync  = {st_q.addr_sync[1:0], host_addr};
      st_d.data_sync  = {st_q.data_sync[1:0], host_data_in};
      st_d.cs_sync    = {st_q.cs_sync[1:0], host_cs_n};
      st_d.rd_sync    = {st_q.rd_sync[1:0], host_rd_n};
      st_d.wr_sync    = {st_q.wr_sync[1:0], host_wr_n};
      st_d.align_sync = {st_q.align_sync[1:0], sync_in};

      // Write commits on the rising edge of the write strobe with chip select held.
      wr_stb    = st_q.wr_sync[1] && !st_q.wr_sync[2] && !st_q.cs_sync[2];
      align_evt = st_q.align_sync[1] && !st_q.align_sync[2] && st_q.ds_reg[ALIGN_EN_BIT];

      if (wr_stb) begin
         unique case (st_q.addr_sync[2])
            ADDR_MULT_SETUP:   st_d.mult_reg = st_q.data_sync[2];
            ADDR_CLK_RELATION: st_d.rel_reg  = st_q.data_sync[2];
            ADDR_PORT_FORMAT:  st_d.fmt_reg  = st_q.data_sync[2];
            ADDR_DOWNSAMPLE:   st_d.ds_reg   = st_q.data_sync[2];
            ADDR_UPSAMPLE:     st_d.up_reg   = st_q.data_sync[2];
            default:           st_d.mult_reg = st_q.mult_reg;
         endcase
      end

      // Multiplier outputs are registered in the same edge as the setup register.
      st_d.mult   = st_d.mult_reg[MULT_LSB +: 2];
      st_d.bypass = (st_d.mult_reg[MULT_LSB +: 2] == MULT_BYPASS);

      // Read data is driven while chip select and read strobe are both low.
      st_d.oe = !st_q.cs_sync[1] && !st_q.rd_sync[1];
      unique case (st_q.addr_sync[1])
         ADDR_MULT_SETUP:   st_d.rdata = st_q.mult_reg;
         ADDR_CLK_RELATION: st_d.rdata = st_q.rel_reg;
         ADDR_PORT_FORMAT:  st_d.rdata = st_q.fmt_reg;
         ADDR_DOWNSAMPLE:   st_d.rdata = st_q.ds_reg;
         ADDR_UPSAMPLE:     st_d.rdata = st_q.up_reg;
         ADDR_STATUS:       st_d.rdata = {6'h00, st_q.phase, 3'h0, st_q.err};
         default:           st_d.rdata = 16'h0000;
      endcase

      // Four core cycles per sample slot; sync realigns to phase zero.
      if (align_evt) begin
         st_d.phase = 2'h0;
      end else begin
         st_d.phase = st_q.phase + 2'h1;
      end
      st_d.slot = (st_d.phase == CYCLES_PER_SAMPLE_M1);

      // Downsample strobe fires on the last slot of each group of factor slots.
      if (align_evt) begin
         st_d.ds_count = 2'h0;
      end else if (st_d.slot) begin
         if (st_q.ds_count >= ds_last(st_q.ds_reg[DS_LSB +: 3])) begin
            st_d.ds_count = 2'h0;
         end else begin
            st_d.ds_count = st_q.ds_count + 2'h1;
         end
      end
      st_d.ds_stb = st_d.slot && !align_evt &&
                    (st_q.ds_count >= ds_last(st_q.ds_reg[DS_LSB +: 3]));

      // Consistency flags; they report only, the host must fix the setup.
      st_d.err[0] = (st_q.ds_reg[DS_LSB +: 3] != DS_BY_1) && (st_q.ds_reg[DS_LSB +: 3] != DS_BY_2) &&
                    (st_q.ds_reg[DS_LSB +: 3] != DS_BY_4);
      st_d.err[1] = (st_q.mult_reg[MULT_LSB +: 2] == MULT_BYPASS) &&
                    (st_q.ds_reg[DS_LSB +: 3] != DS_BY_4);
      st_d.err[2] = (st_q.fmt_reg[OUT_FMT_LSB +: 2] == OUT_ODD_EVEN) &&
                    (st_q.up_reg[UP_LSB +: 2] != UP_2X_REAL) && (st_q.up_reg[UP_LSB +: 2] != UP_4X_REAL);
      st_d.err[3] = st_q.fmt_reg[TWO_CH_BIT] && !st_q.fmt_reg[IN_MUX_BIT];
      st_d.err[4] = st_q.fmt_reg[TWO_CH_BIT] &&
                    ((st_q.ds_reg[DS_LSB +: 3] == DS_BY_4) || (st_q.up_reg[UP_LSB +: 2] == UP_4X_REAL));
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         st_q            <= '0;
         st_q.cs_sync    <= 3'h7;
         st_q.rd_sync    <= 3'h7;
         st_q.wr_sync    <= 3'h7;
         st_q.ds_reg     <= RESET_DOWNSAMPLE;
         st_q.mult_reg   <= RESET_VALUE;
      end else begin
         st_q <= st_d;
      end
   end

   assign mult_sel          = st_q.mult;
   assign mult_bypass       = st_q.bypass;
   assign feedback_src      = st_q.mult_reg[FB_SRC_BIT];
   assign in_clk_relation   = st_q.rel_reg[IN_REL_LSB +: 2];
   assign out_clk_relation  = st_q.rel_reg[OUT_REL_LSB +: 2];
   assign two_channel       = st_q.fmt_reg[TWO_CH_BIT];
   assign in_muxed          = st_q.fmt_reg[IN_MUX_BIT];
   assign out_format        = st_q.fmt_reg[OUT_FMT_LSB +: 2];
   assign upsample_mode     = st_q.up_reg[UP_LSB +: 2];
   assign downsample_factor = st_q.ds_reg[DS_LSB +: 3];
   assign slot_phase        = st_q.phase;
   assign slot_strobe       = st_q.slot;
   assign downsample_strobe = st_q.ds_stb;
   assign config_error      = st_q.err;
   assign host_data_out     = st_q.rdata;
   assign host_data_oe      = st_q.oe;

   property p_mult_write;
      @(posedge clk_sys) disable iff (!arst_n)
      wr_stb && (st_q.addr_sync[2] == ADDR_MULT_SETUP) |=> mult_sel == $past(st_q.data_sync[2][1:0]);
   endproperty
   a_mult_write: assert property (p_mult_write) else $error("multiplier select not taken from write");

   property p_slot_four;
      @(posedge clk_sys) disable iff (!arst_n)
      slot_strobe && !align_evt ##1 (!align_evt)[*3] |=> slot_strobe;
   endproperty
   a_slot_four: assert property (p_slot_four) else $error("sample slot is not four cycles");

   property p_slot_single;
      @(posedge clk_sys) disable iff (!arst_n)
      slot_strobe |=> !slot_strobe;
   endproperty
   a_slot_single: assert property (p_slot_single) else $error("slot strobe longer than one cycle");

   property p_bypass;
      @(posedge clk_sys) disable iff (!arst_n)
      wr_stb && (st_q.addr_sync[2] == ADDR_MULT_SETUP) && (st_q.data_sync[2][1:0] == MULT_BYPASS)
      |=> mult_bypass ##1 (mult_sel == MULT_BYPASS);
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypass not selected after write");

   property p_fb_src;
      @(posedge clk_sys) disable iff (!arst_n)
      wr_stb && (st_q.addr_sync[2] == ADDR_MULT_SETUP) |=> feedback_src == $past(st_q.data_sync[2][4]);
   endproperty
   a_fb_src: assert property (p_fb_src) else $error("feedback source not taken from write");

   property p_relation;
      @(posedge clk_sys) disable iff (!arst_n)
      wr_stb && (st_q.addr_sync[2] == ADDR_CLK_RELATION) |=> out_clk_relation == $past(st_q.data_sync[2][3:2]);
   endproperty
   a_relation: assert property (p_relation) else $error("clock relation not taken from write");

   property p_format;
      @(posedge clk_sys) disable iff (!arst_n)
      wr_stb && (st_q.addr_sync[2] == ADDR_PORT_FORMAT) |=> two_channel == $past(st_q.data_sync[2][0]);
   endproperty
   a_format: assert property (p_format) else $error("channel count not taken from write");

   property p_ds_in_slot;
      @(posedge clk_sys) disable iff (!arst_n)
      downsample_strobe |-> slot_strobe && (slot_phase == 2'h3);
   endproperty
   a_ds_in_slot: assert property (p_ds_in_slot) else $error("downsample strobe outside slot end");

   property p_align;
      @(posedge clk_sys) disable iff (!arst_n)
      align_evt |=> (slot_phase == 2'h0) ##3 slot_strobe;
   endproperty
   a_align: assert property (p_align) else $error("phase counter did not realign");

endmodule

//--- inc/cmc_pkg.sv
/*
 * Constants for the core clock mode control block: register offsets on the
 * 8-bit host address bus, field positions and codes.
 * Assumes a 16-bit host data bus and a single system clock.
 */
package cmc_pkg;

   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 16;

   localparam logic [7:0] ADDR_MULT_SETUP   = 8'h01;
   localparam logic [7:0] ADDR_CLK_RELATION = 8'h02;
   localparam logic [7:0] ADDR_PORT_FORMAT  = 8'h09;
   localparam logic [7:0] ADDR_DOWNSAMPLE   = 8'h0C;
   localparam logic [7:0] ADDR_STATUS       = 8'h7F;
   localparam logic [7:0] ADDR_UPSAMPLE     = 8'h80;

   localparam logic [15:0] RESET_VALUE      = 16'h0000;
   localparam logic [15:0] RESET_DOWNSAMPLE = 16'h0001;

   // Multiplier setup fields.
   localparam int unsigned MULT_LSB   = 0;
   localparam int unsigned FB_SRC_BIT = 4;
   // Clock relation fields.
   localparam int unsigned IN_REL_LSB  = 0;
   localparam int unsigned OUT_REL_LSB = 2;
   // Port format fields.
   localparam int unsigned TWO_CH_BIT  = 0;
   localparam int unsigned IN_MUX_BIT  = 1;
   localparam int unsigned OUT_FMT_LSB = 2;
   // Downsample fields.
   localparam int unsigned DS_LSB       = 0;
   localparam int unsigned ALIGN_EN_BIT = 8;
   // Upsample fields.
   localparam int unsigned UP_LSB = 0;
   // Status fields.
   localparam int unsigned ERR_LSB   = 0;
   localparam int unsigned PHASE_LSB = 8;

   localparam logic [1:0] OUT_PARALLEL = 2'h0;
   localparam logic [1:0] OUT_MUXED    = 2'h1;
   localparam logic [1:0] OUT_ODD_EVEN = 2'h2;

   localparam logic [1:0] UP_BYPASS  = 2'h0;
   localparam logic [1:0] UP_2X_CPLX = 2'h1;
   localparam logic [1:0] UP_2X_REAL = 2'h2;
   localparam logic [1:0] UP_4X_REAL = 2'h3;

   localparam logic [2:0] DS_BY_1 = 3'h1;
   localparam logic [2:0] DS_BY_2 = 3'h2;
   localparam logic [2:0] DS_BY_4 = 3'h4;

   localparam logic [1:0] CYCLES_PER_SAMPLE_M1 = 2'h3;

   typedef enum logic [1:0] {
      MULT_X1     = 2'b00,
      MULT_X2     = 2'b01,
      MULT_X4     = 2'b10,
      MULT_BYPASS = 2'b11
   } cmc_mult_e;

endpackage

//--- sim/cmc_src_model.sv
/*
 * Upstream sample source model: gives the downsample phase align pulse.
 * Assumes it shares clk_sys, which stands in for the input sample clock.
 */
`timescale 1ns/10ps
module cmc_src_model (
   input  wire logic clk_sys,
   output logic      sync_out
);
   initial sync_out = 1'b0;
   // The pulse lasts four cycles, the span that one bypass sample is held.
   task automatic align_pulse();
      @(posedge clk_sys);
      #2 sync_out = 1'b1;
      repeat (4) @(posedge clk_sys);
      #2 sync_out = 1'b0;
   endtask
endmodule

//--- sim/cfr_clock_mode_control_tb.sv
/*
 * Self-checking bench for the core clock mode control block.
 * Assumes host strobes held four clocks and a 40 MHz clk_sys.
 */
`timescale 1ns/10ps
module cfr_clock_mode_control_tb;
   import cmc_pkg::*;
   logic        clk_sys = 1'b0, arst_n = 1'b0, host_cs_n = 1'b1, host_rd_n = 1'b1, host_wr_n = 1'b1;
   logic [7:0]  host_addr = 8'h00;
   logic [15:0] host_data_in = 16'h0000, host_data_out, rv;
   logic        host_data_oe, mult_bypass, feedback_src, two_channel, in_muxed, sync_in;
   logic        slot_strobe, downsample_strobe;
   logic [1:0]  mult_sel, in_clk_relation, out_clk_relation, out_format, upsample_mode, slot_phase;
   logic [2:0]  downsample_factor;
   logic [4:0]  config_error;
   logic [15:0] cm, cf, cd, cu;
   int          num_errors = 0, n_compared = 0, seed = 32'he2f2, n, n0;
   logic [7:0]  rst_addr [5] = '{ADDR_MULT_SETUP, ADDR_CLK_RELATION, ADDR_PORT_FORMAT, ADDR_UPSAMPLE, 8'h55};
   logic [2:0]  ds_code [4] = '{3'h1, 3'h2, 3'h4, 3'h3};
   // The 40 MHz input clock stays in range for the 4x and bypass multiplier modes.
   always #12.5 clk_sys = ~clk_sys;
   cmc_clock_mode_control u_dut (.clk_sys(clk_sys), .arst_n(arst_n), .host_addr(host_addr),
      .host_data_in(host_data_in), .host_data_out(host_data_out), .host_data_oe(host_data_oe),
      .host_cs_n(host_cs_n), .host_rd_n(host_rd_n), .host_wr_n(host_wr_n), .sync_in(sync_in),
      .mult_sel(mult_sel), .mult_bypass(mult_bypass), .feedback_src(feedback_src),
      .in_clk_relation(in_clk_relation), .out_clk_relation(out_clk_relation),
      .two_channel(two_channel), .in_muxed(in_muxed), .out_format(out_format),
      .upsample_mode(upsample_mode), .downsample_factor(downsample_factor), .slot_phase(slot_phase),
      .slot_strobe(slot_strobe), .downsample_strobe(downsample_strobe), .config_error(config_error));
   cmc_src_model u_src (.clk_sys(clk_sys), .sync_out(sync_in));
   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
      n_compared++;
      if (g !== e) begin
         num_errors++;
         $display("BAD t=%0t %s got %h exp %h", $time, m, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      #2 {host_addr, host_data_in, host_cs_n, host_wr_n} = {a, d, 2'b00};
      repeat (4) @(posedge clk_sys);
      #2 host_wr_n = 1'b1;
      repeat (4) @(posedge clk_sys);
      #2 host_cs_n = 1'b1;
      repeat (3) @(posedge clk_sys);
   endtask
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk_sys);
      #2 {host_addr, host_cs_n, host_rd_n} = {a, 2'b00};
      repeat (4) @(posedge clk_sys);
      #2 chk(host_data_oe, 1, "oe on");
      d = host_data_out;
      {host_cs_n, host_rd_n} = 2'b11;
      repeat (4) @(posedge clk_sys);
      #2 chk(host_data_oe, 0, "oe off");
   endtask
   function automatic logic [4:0] exp_err(logic [15:0] m, logic [15:0] f, logic [15:0] d, logic [15:0] u);
      logic ok;
      ok = d[2:0] inside {DS_BY_1, DS_BY_2, DS_BY_4};
      return {f[0] & (d[2:0] == DS_BY_4 || u[1:0] == UP_4X_REAL), f[0] & ~f[1],
              f[3:2] == OUT_ODD_EVEN && u[1:0] < UP_2X_REAL, m[1:0] == MULT_BYPASS && d[2:0] != DS_BY_4, ~ok};
   endfunction
   task automatic strobe_gap(output int c);
      c = 0;
      while (slot_strobe !== 1'b1 && c < 20) begin
         @(posedge clk_sys);
         #2 c++;
      end
   endtask
   initial begin
      #(25 * 30000) num_errors++;
      conclude();
   end
   initial begin
      repeat (8) @(posedge clk_sys);
      #2 arst_n = 1'b1;
      chk({mult_sel, mult_bypass, feedback_src, in_clk_relation, out_clk_relation}, 0, "reset cfg");
      chk({two_channel, in_muxed, out_format, upsample_mode, downsample_factor}, 1, "reset fmt");
      foreach (rst_addr[i]) begin
         rd(rst_addr[i], rv);
         chk(rv, RESET_VALUE, "reset read");
      end
      rd(ADDR_DOWNSAMPLE, rv);
      chk(rv, RESET_DOWNSAMPLE, "reset ds");
      wr(8'h55, 16'hFFFF);
      chk(mult_sel, 0, "unmapped write");
      $display("test reset done");
      for (int k = 0; k < 8; k++) begin
         wr(ADDR_MULT_SETUP, {11'h000, k[2], 2'h0, k[1:0]});
         chk({mult_sel, mult_bypass, feedback_src}, {k[1:0], k[1:0] == 2'h3, k[2]}, "mult");
      end
      $display("test mult done");
      for (int k = 0; k < 14; k++) begin
         cm = 16'($random(seed));
         cf = 16'($random(seed));
         cd = 16'($random(seed)) & 16'h0007;
         cu = 16'($random(seed));
         if (k == 0) {cm, cf, cd, cu} = {16'h0003, 16'h0003, 16'h0004, 16'h0000};
         if (k == 1) {cm, cf, cd, cu} = {16'h0003, 16'h0008, 16'h0002, 16'h0001};
         if (k == 2) {cm, cf, cd, cu} = {16'h0000, 16'h0009, 16'h0004, 16'h0003};
         wr(ADDR_MULT_SETUP, cm);
         wr(ADDR_CLK_RELATION, cf);
         chk({in_clk_relation, out_clk_relation}, {cf[1:0], cf[3:2]}, "relation");
         wr(ADDR_PORT_FORMAT, cf);
         wr(ADDR_DOWNSAMPLE, cd);
         wr(ADDR_UPSAMPLE, cu);
         chk({two_channel, in_muxed, out_format}, {cf[0], cf[1], cf[3:2]}, "format");
         chk({upsample_mode, downsample_factor}, {cu[1:0], cd[2:0]}, "rates");
         chk(config_error, exp_err(cm, cf, cd, cu), "cfg err");
         rd(ADDR_STATUS, rv);
         chk(rv[4:0], exp_err(cm, cf, cd, cu), "status err");
         rd(ADDR_UPSAMPLE, rv);
         chk(rv, cu, "up read");
      end
      $display("test config done");
      foreach (ds_code[i]) begin
         wr(ADDR_DOWNSAMPLE, {13'h0000, ds_code[i]});
         #2 n = 0;
         while (downsample_strobe !== 1'b1 && n < 40) begin
            @(posedge clk_sys);
            #2 n++;
         end
         n = 0;
         do begin
            @(posedge clk_sys);
            #2 n++;
            if (slot_strobe === 1'b1) chk(slot_phase, CYCLES_PER_SAMPLE_M1, "slot phase");
         end while (downsample_strobe !== 1'b1 && n < 40);
         chk(16'(n), 16'(4 * ((i == 3) ? 1 : int'(ds_code[i]))), "ds period");
      end
      $display("test downsample done");
      wr(ADDR_DOWNSAMPLE, 16'h0104);
      for (int k = 0; k < 2; k++) begin
         repeat (k + 1) @(posedge clk_sys);
         fork
            u_src.align_pulse();
         join_none
         // Pin rise, two sync stages and the edge detector put phase zero four edges on.
         repeat (4) @(posedge clk_sys);
         #2 chk(slot_phase, 16'h0000, "align phase");
         strobe_gap(n);
         if (k == 0) n0 = n;
         else chk(16'(n), 16'(n0), "align latency");
         chk(16'(n), 16'(CYCLES_PER_SAMPLE_M1), "align bound");
         repeat (6) @(posedge clk_sys);
      end
      $display("test align done");
      conclude();
   end
endmodule
